// ### ptmr_pkg.sv
/*
  Package for the periodic timer: register offsets, field positions,
  reset values and mode encodings.
  Assumes a 32-bit APB with one aligned word per register.
*/
package ptmr_pkg;
  // ==========================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_CNT_LO = 8'h08;
  localparam logic [7:0] OFF_CNT_HI = 8'h0C;
  localparam logic [7:0] OFF_CMPA_LO = 8'h10;
  localparam logic [7:0] OFF_CMPA_HI = 8'h14;
  localparam logic [7:0] OFF_CMPP_LO = 8'h18;
  localparam logic [7:0] OFF_CMPP_HI = 8'h1C;
  // ==========================================
  // Field positions
  localparam int CTRL0_EN_BIT = 3;
  localparam int CTRL1_MODE_HI = 7;
  localparam int CTRL1_MODE_LO = 6;
  localparam int CTRL1_FUNC_HI = 5;
  localparam int CTRL1_FUNC_LO = 4;
  localparam int CTRL1_OLC_BIT = 3;
  localparam int CTRL1_POL_BIT = 2;
  localparam int CTRL1_CSS_BIT = 1;
  localparam int CTRL1_CCS_BIT = 0;
  // ==========================================
  // Reset values and limits
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [9:0] VAL_RST = 10'h000;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  // ==========================================
  // Modes and pin functions
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] FN_NONE = 2'h0;
  localparam logic [1:0] FN_LOW = 2'h1;
  localparam logic [1:0] FN_HIGH = 2'h2;
  localparam logic [1:0] FN_TOG = 2'h3;
  localparam logic [1:0] FN_PWM = 2'h2;
  localparam logic [1:0] FN_SP = 2'h3;
endpackage

// ### ptmr_top.sv
/*
  Periodic timer core with APB register slave: 10-bit up counter,
  comparators A and P, output pin logic and capture.
  Assumes pins are asynchronous to clk_i and the counter ticks every clk_i.
*/
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: Compare mode: output level bit sets pin level before any A match.
// RULE_02: PWM mode: output level bit picks waveform active level.
// RULE_03: Single pulse: output level bit is level driven at enable rise.
// RULE_04: Timer/counter mode: level and polarity bits do not affect pin.
// RULE_05: Polarity bit set inverts pin level, clear passes it.
// RULE_06: Capture source is capture pin at 0, external clock pin at 1.
// RULE_07: Clear select 1 clears counter on comparator A match.
// RULE_08: Clear select 0 clears on comparator P match or overflow.
// RULE_09: Overflow clear only when compare P is zero.
// RULE_10: Clear select ignored in PWM, single pulse and capture modes.
// RULE_11: Counter readable as low byte and two high bits, read only.
// RULE_12: Compare A readable and writable as low byte and two high bits.
// RULE_13: Compare P readable and writable as low byte and two high bits.
// RULE_14: High registers read zero in bits 7 to 2.
// RULE_15: Five modes: compare, PWM, single pulse, capture, timer/counter.
// RULE_16: Mode field 00 compare, 01 capture, 10 PWM/pulse, 11 timer.
// RULE_17: Enable rise zeroes counter; enable fall stops and holds it.
// RULE_18: Uncleared counter overflows at 3FF.
// RULE_19: Polarity inversion is the final stage before the pin.
module ptmr_top import ptmr_pkg::*; (
  input wire logic clk_i, // 10 MHz clock
  input wire logic resetn_i, // async reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error on unmapped address
  input wire logic capture_input_pin_i, // capture pin
  input wire logic external_clock_pin_i, // external clock pin
  output logic timer_output_pin_o, // timer output pin
  output logic match_a_o, // comparator A match pulse
  output logic match_p_o // comparator P match or overflow pulse
);
  typedef enum logic [1:0] {PH_IDLE = 2'b01, PH_ACC = 2'b10} ptmr_ph_t;
  typedef struct packed {
    ptmr_ph_t ph;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [9:0] cnt;
    logic [9:0] cmpa;
    logic [9:0] cmpp;
    logic en_d;
    logic ext_d;
    logic lvl;
    logic pin;
    logic [1:0] cap_s1;
    logic [1:0] cap_s2;
    logic cap_d;
    logic ma;
    logic mp;
  } ptmr_state_t;

  ptmr_state_t s_r, s_nxt;

  logic [1:0] mode, fn;
  logic en, olc, pol, css, ccs, trig;
  logic hit_a, hit_p, ovf, clr, cap_edge, base, wr_acc, rd_hit;
  logic [7:0] rbyte;

  always_comb begin
    mode = s_r.ctrl1[CTRL1_MODE_HI:CTRL1_MODE_LO]; // RULE_16
    fn = s_r.ctrl1[CTRL1_FUNC_HI:CTRL1_FUNC_LO];
    en = s_r.ctrl0[CTRL0_EN_BIT];
    olc = s_r.ctrl1[CTRL1_OLC_BIT];
    pol = s_r.ctrl1[CTRL1_POL_BIT];
    css = s_r.ctrl1[CTRL1_CSS_BIT];
    ccs = s_r.ctrl1[CTRL1_CCS_BIT];
    trig = css ? s_r.cap_s2[1] : s_r.cap_s2[0]; // RULE_06
    hit_a = en && (s_r.cnt == s_r.cmpa);
    hit_p = en && (s_r.cnt == s_r.cmpp);
    ovf = en && (s_r.cnt == CNT_MAX); // RULE_18
    // ==========================================
    // Clear selection
    clr = 1'b0;
    case (mode)
      MODE_CMP, MODE_TMR: begin
        if (ccs) begin
          clr = hit_a && (s_r.cmpa != VAL_RST); // RULE_07
        end else begin
          clr = (s_r.cmpp == VAL_RST) ? ovf : hit_p; // RULE_08 RULE_09
        end
      end
      MODE_PWM: clr = (fn == FN_SP) ? 1'b0 : ((s_r.cmpp == VAL_RST) ? ovf : hit_p); // RULE_10
      MODE_CAP: clr = ovf; // RULE_10
      default: clr = 1'b0;
    endcase
    cap_edge = 1'b0;
    case (fn)
      2'h0: cap_edge = trig && !s_r.cap_d;
      2'h1: cap_edge = !trig && s_r.cap_d;
      2'h2: cap_edge = trig != s_r.cap_d;
      default: cap_edge = 1'b0;
    endcase
    wr_acc = psel_i && penable_i && pwrite_i && (s_r.ph == PH_ACC);
    rd_hit = 1'b1;
    rbyte = 8'h00;
    case (paddr_i)
      OFF_CTRL0: rbyte = s_r.ctrl0 & 8'hF8;
      OFF_CTRL1: rbyte = s_r.ctrl1;
      OFF_CNT_LO: rbyte = s_r.cnt[7:0]; // RULE_11
      OFF_CNT_HI: rbyte = {6'h00, s_r.cnt[9:8]}; // RULE_11 RULE_14
      OFF_CMPA_LO: rbyte = s_r.cmpa[7:0]; // RULE_12
      OFF_CMPA_HI: rbyte = {6'h00, s_r.cmpa[9:8]}; // RULE_12 RULE_14
      OFF_CMPP_LO: rbyte = s_r.cmpp[7:0]; // RULE_13
      OFF_CMPP_HI: rbyte = {6'h00, s_r.cmpp[9:8]}; // RULE_13 RULE_14
      default: rd_hit = 1'b0;
    endcase

    s_nxt = s_r;
    s_nxt.ready = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.cap_s1 = {external_clock_pin_i, capture_input_pin_i};
    s_nxt.cap_s2 = s_r.cap_s1;
    s_nxt.cap_d = trig;
    s_nxt.en_d = en;
    s_nxt.ext_d = s_r.cap_s2[1];
    s_nxt.ma = hit_a;
    // With compare P at zero only the overflow ends a period, not the pass through zero
    s_nxt.mp = (s_r.cmpp == VAL_RST) ? ovf : hit_p; // RULE_09
    // ==========================================
    // APB slave: one wait state, answer in the access phase's second cycle
    case (s_r.ph)
      PH_IDLE: begin
        if (psel_i && !penable_i) begin
          s_nxt.ph = PH_ACC;
        end
      end
      PH_ACC: begin
        if (psel_i && penable_i && !s_r.ready) begin
          s_nxt.ready = 1'b1;
          s_nxt.err = !rd_hit;
          s_nxt.rdata = {24'h000000, rbyte};
        end
        if (s_r.ready) begin
          s_nxt.ph = PH_IDLE;
        end
      end
      default: s_nxt.ph = PH_IDLE;
    endcase
    if (wr_acc && s_r.ready) begin
      case (paddr_i)
        OFF_CTRL0: s_nxt.ctrl0 = pwdata_i[7:0] & 8'hF8;
        OFF_CTRL1: s_nxt.ctrl1 = pwdata_i[7:0];
        OFF_CMPA_LO: s_nxt.cmpa[7:0] = pwdata_i[7:0]; // RULE_12
        OFF_CMPA_HI: s_nxt.cmpa[9:8] = pwdata_i[1:0]; // RULE_12
        OFF_CMPP_LO: s_nxt.cmpp[7:0] = pwdata_i[7:0]; // RULE_13
        OFF_CMPP_HI: s_nxt.cmpp[9:8] = pwdata_i[1:0]; // RULE_13
        default: ;
      endcase
    end
    // ==========================================
    // Counter and mode logic
    if (en && !s_r.en_d) begin
      s_nxt.cnt = VAL_RST; // RULE_17
    end else if (en) begin
      s_nxt.cnt = clr ? VAL_RST : 10'(s_r.cnt + 10'h001); // RULE_18
    end
    if (mode == MODE_CAP && en && cap_edge) begin
      s_nxt.cmpa = s_r.cnt;
    end
    // Single pulse: with capture source 0 an external pin rise starts it, A match ends it
    if (mode == MODE_PWM && fn == FN_SP) begin
      if (!en && s_r.cap_s2[1] && !s_r.ext_d && css == 1'b0) begin
        s_nxt.ctrl0[CTRL0_EN_BIT] = 1'b1;
      end
      if (en && s_r.en_d && hit_a) begin
        s_nxt.ctrl0[CTRL0_EN_BIT] = 1'b0;
      end
    end
    if (en && !s_r.en_d) begin
      s_nxt.lvl = olc; // RULE_01 RULE_03
    end else if (mode == MODE_CMP && en && hit_a && s_r.cmpa != VAL_RST) begin // RULE_15
      case (fn)
        FN_LOW: s_nxt.lvl = 1'b0;
        FN_HIGH: s_nxt.lvl = 1'b1;
        FN_TOG: s_nxt.lvl = !s_r.lvl;
        default: s_nxt.lvl = s_r.lvl;
      endcase
    end
    base = s_r.lvl;
    case (mode)
      MODE_CMP: base = s_nxt.lvl;
      MODE_PWM: begin
        case (fn)
          FN_NONE: base = !olc; // RULE_02
          FN_LOW: base = olc;
          FN_PWM: base = (s_r.cnt < s_r.cmpa) ? olc : !olc; // RULE_02
          default: base = en ? olc : !olc; // RULE_03
        endcase
      end
      default: base = s_r.pin; // RULE_04
    endcase
    if (mode == MODE_CMP || mode == MODE_PWM) begin
      s_nxt.pin = base ^ pol; // RULE_05 RULE_19
    end else begin
      s_nxt.pin = s_r.pin; // RULE_04
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '{ph: PH_IDLE, rdata: 32'h00000000, ready: 1'b0, err: 1'b0,
               ctrl0: CTRL_RST, ctrl1: CTRL_RST, cnt: VAL_RST, cmpa: VAL_RST,
               cmpp: VAL_RST, en_d: 1'b0, ext_d: 1'b0, lvl: 1'b0, pin: 1'b0,
               cap_s1: 2'h0, cap_s2: 2'h0, cap_d: 1'b0, ma: 1'b0, mp: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata_o = s_r.rdata;
  assign pready_o = s_r.ready;
  assign pslverr_o = s_r.err;
  assign timer_output_pin_o = s_r.pin;
  assign match_a_o = s_r.ma;
  assign match_p_o = s_r.mp;

  // ==========================================
  // Checks
  sequence en_rise;
    s_r.ctrl0[CTRL0_EN_BIT] && !s_r.en_d;
  endsequence

  sequence en_steady;
    en && s_r.en_d;
  endsequence

  sequence bus_write;
    wr_acc && s_r.ready;
  endsequence

  sequence pulse_start;
    en && !s_r.en_d && mode == MODE_PWM && fn == FN_SP;
  endsequence

  a_enable_zeroes: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_17
    en_rise |=> s_r.cnt == VAL_RST) else $error("counter not zeroed on enable rise");
  a_disable_holds: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_17
    !en && !s_r.en_d |=> $stable(s_r.cnt)) else $error("counter moved while off");
  a_initial_level: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_01
    en_rise and (mode == MODE_CMP) |=> timer_output_pin_o == ($past(olc) ^ $past(pol)))
    else $error("initial level wrong");
  a_timer_pin_held: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_04
    mode == MODE_TMR && $past(mode) == MODE_TMR |-> $stable(timer_output_pin_o))
    else $error("pin moved in timer mode");
  a_clear_on_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_07
    en && s_r.en_d && mode == MODE_CMP && ccs && hit_a && s_r.cmpa != VAL_RST && !wr_acc
    |=> s_r.cnt == VAL_RST) else $error("no clear on A match");
  a_clear_on_p: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_08
    en && s_r.en_d && mode == MODE_TMR && !ccs && hit_p && s_r.cmpp != VAL_RST && !wr_acc
    |=> s_r.cnt == VAL_RST) else $error("no clear on P match");
  a_wrap_at_max: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_18
    en && s_r.en_d && s_r.cnt == CNT_MAX |=> s_r.cnt == VAL_RST) else $error("no overflow");
  a_high_zero: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_14
    pready_o && paddr_i == OFF_CNT_HI |-> prdata_o[7:2] == 6'h00) else $error("high bits set");

  // ==========================================
  // Clear, pulse, pin, capture and register checks
  a_p_match_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_08
    en_steady and (s_r.cmpp != VAL_RST && hit_p)
    |=> match_p_o)
    else $error("no P match pulse");
  a_ovf_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_09
    s_r.cmpp == VAL_RST && en && s_r.cnt == VAL_RST
    |=> !match_p_o)
    else $error("period pulse at zero with compare P zero");
  a_clear_on_ovf: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_09
    en_steady and (mode == MODE_CMP && !ccs && s_r.cmpp == VAL_RST && s_r.cnt == CNT_MAX && !wr_acc)
    |=> s_r.cnt == VAL_RST)
    else $error("no clear on overflow");
  a_pwm_ignores_sel: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_10
    en_steady and (mode == MODE_PWM && fn == FN_PWM && ccs && hit_a && !hit_p && s_r.cnt != CNT_MAX && !wr_acc)
    |=> s_r.cnt == 10'($past(s_r.cnt) + 10'h001))
    else $error("clear select used in PWM mode");
  a_cap_ignores_sel: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_10
    en_steady and (mode == MODE_CAP && ccs && hit_a && s_r.cnt != CNT_MAX && !wr_acc)
    |=> s_r.cnt == 10'($past(s_r.cnt) + 10'h001))
    else $error("clear select used in capture mode");
  a_pulse_no_clear: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_10
    en_steady and (mode == MODE_PWM && fn == FN_SP && hit_p && s_r.cnt != CNT_MAX && !wr_acc)
    |=> s_r.cnt == 10'($past(s_r.cnt) + 10'h001))
    else $error("counter cleared in single pulse mode");
  a_pulse_level: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_03
    pulse_start
    |=> timer_output_pin_o == ($past(olc) ^ $past(pol)))
    else $error("pulse start level wrong");
  a_pulse_end: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_15
    en_steady and (mode == MODE_PWM && fn == FN_SP && hit_a && !wr_acc)
    |=> !en)
    else $error("pulse not ended by A match");
  a_pwm_wave: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_02
    en_steady and (mode == MODE_PWM && fn == FN_PWM)
    |=> timer_output_pin_o == ((($past(s_r.cnt) < $past(s_r.cmpa)) ? $past(olc) : !$past(olc)) ^ $past(pol)))
    else $error("PWM level wrong");
  a_polarity_last: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_19
    mode == MODE_CMP && !(en && !s_r.en_d) && !hit_a
    |=> timer_output_pin_o == ($past(s_r.lvl) ^ $past(pol)))
    else $error("polarity not applied last");
  a_compare_toggle: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_15
    en_steady and (mode == MODE_CMP && fn == FN_TOG && hit_a && s_r.cmpa != VAL_RST)
    |=> s_r.lvl == !$past(s_r.lvl))
    else $error("no toggle on A match");
  a_capture_store: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_06
    mode == MODE_CAP && en && cap_edge
    |=> s_r.cmpa == $past(s_r.cnt))
    else $error("capture not stored");
  a_capture_src: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_06
    mode == MODE_CAP && en && fn == 2'h0 && !css && s_r.cap_s2[0] && !s_r.cap_d
    |=> s_r.cmpa == $past(s_r.cnt))
    else $error("capture pin edge missed");
  a_count_low_read: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_11
    s_r.ph == PH_ACC && psel_i && penable_i && !s_r.ready && paddr_i == OFF_CNT_LO
    |=> prdata_o == {24'h000000, $past(s_r.cnt[7:0])})
    else $error("counter low byte read wrong");
  a_count_ro: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_11
    bus_write and (!en && (paddr_i == OFF_CNT_LO || paddr_i == OFF_CNT_HI))
    |=> $stable(s_r.cnt))
    else $error("counter written by bus");
  a_write_a_low: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_12
    bus_write and (paddr_i == OFF_CMPA_LO && mode != MODE_CAP)
    |=> s_r.cmpa[7:0] == $past(pwdata_i[7:0]))
    else $error("compare A low write lost");
  a_write_a_high: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_12
    bus_write and (paddr_i == OFF_CMPA_HI && mode != MODE_CAP)
    |=> s_r.cmpa[9:8] == $past(pwdata_i[1:0]))
    else $error("compare A high write lost");
  a_write_p_low: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_13
    bus_write and (paddr_i == OFF_CMPP_LO)
    |=> s_r.cmpp[7:0] == $past(pwdata_i[7:0]))
    else $error("compare P low write lost");
  a_write_p_high: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_13
    bus_write and (paddr_i == OFF_CMPP_HI)
    |=> s_r.cmpp[9:8] == $past(pwdata_i[1:0]))
    else $error("compare P high write lost");
  a_high_zero_cmp: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_14
    pready_o && (paddr_i == OFF_CMPA_HI || paddr_i == OFF_CMPP_HI)
    |-> prdata_o[7:2] == 6'h00)
    else $error("compare high bits set");
endmodule // ptmr_top

// ### ptmr_pins.sv
/*
  Pin-side model for the periodic timer: drives the capture and
  external clock pins on request of the bench.
  Assumes the caller runs on the same clock as the timer.
*/
`timescale 1ns/1ps
module ptmr_pins (
  input wire logic clk_i, // bench clock
  output logic capture_input_pin_o, // to capture pin
  output logic external_clock_pin_o // to external clock pin
);
  // ==========================================
  // Pulse generator
  initial begin
    capture_input_pin_o = 1'b0;
    external_clock_pin_o = 1'b0;
  end
  // Four cycles per level so the two-flop synchroniser cannot miss an edge
  task automatic pulse(input bit ext);
    @(posedge clk_i);
    if (ext) external_clock_pin_o <= 1'b1;
    else capture_input_pin_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    external_clock_pin_o <= 1'b0;
    capture_input_pin_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // ptmr_pins

// ### ptmr_top_tb.sv
/*
  Self-checking bench for ptmr_top: registers over APB, clear periods,
  output pin levels and capture source.
  Assumes the one-wait-state APB answer and per-clock counting.
*/
`timescale 1ns/1ps
module ptmr_top_tb;
  import ptmr_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, r, v;
  logic pready_o, pslverr_o, cap_pin, ext_pin, timer_output_pin_o, match_a_o, match_p_o, e;
  logic [7:0] mb [3] = '{8'h00, 8'hA0, 8'hB0};
  int miscompares = 0;
  int n_tests = 0;
  always #50 clk_i = ~clk_i;
  ptmr_top u_ptmr_top (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .capture_input_pin_i(cap_pin), .external_clock_pin_i(ext_pin),
    .timer_output_pin_o(timer_output_pin_o), .match_a_o(match_a_o), .match_p_o(match_p_o));
  ptmr_pins u_ptmr_pins (.clk_i(clk_i), .capture_input_pin_o(cap_pin), .external_clock_pin_o(ext_pin));
  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  // Mode changes are made with the timer off, then the enable rise restarts it
  task automatic cfg(input logic [7:0] d);
    wr(OFF_CTRL0, 8'h00);
    wr(OFF_CTRL1, d);
    wr(OFF_CTRL0, 8'h08);
  endtask
  task automatic per(input bit p, input int x);
    int n;
    n = 0;
    do @(posedge clk_i); while ((p ? match_p_o : match_a_o) !== 1'b1 && ++n < 3000);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((p ? match_p_o : match_a_o) !== 1'b1 && n < 3000);
    chk(n, x);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    tally_and_finish;
  end
  // ==========================================
  // Tests
  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
    wr(OFF_CNT_LO, 8'hFF);
    rd(OFF_CNT_LO, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(OFF_CMPA_LO, 8'hA5);
    wr(OFF_CMPA_HI, 8'hFF);
    wr(OFF_CMPP_LO, 8'h5A);
    wr(OFF_CMPP_HI, 8'hFE);
    rd(OFF_CMPA_LO, 32'hA5);
    rd(OFF_CMPA_HI, 32'h3);
    rd(OFF_CMPP_LO, 32'h5A);
    rd(OFF_CMPP_HI, 32'h2);
    done("registers");
    wr(OFF_CMPP_LO, 8'h05);
    wr(OFF_CMPP_HI, 8'h00);
    wr(OFF_CMPA_LO, 8'h03);
    wr(OFF_CMPA_HI, 8'h00);
    cfg(8'h00);
    per(1'b1, 6);
    cfg(8'h01);
    per(1'b0, 4);
    cfg(8'hA1);
    per(1'b1, 6);
    wr(OFF_CMPP_LO, 8'h00);
    cfg(8'hC0);
    per(1'b1, 1024);
    wr(OFF_CTRL0, 8'h00);
    apb(1'b0, OFF_CNT_LO, 32'h0);
    v = r;
    repeat (20) @(posedge clk_i);
    rd(OFF_CNT_LO, v);
    done("clear");
    // Compare A above the period keeps PWM steady at its active level
    wr(OFF_CMPP_LO, 8'h05);
    wr(OFF_CMPA_LO, 8'h06);
    wr(OFF_CMPA_HI, 8'h03);
    for (int m = 0; m < 3; m++)
      for (int i = 0; i < 4; i++) begin
        cfg(mb[m] | 8'(i << 2));
        repeat (4) @(posedge clk_i);
        chk({31'h0, timer_output_pin_o}, {31'h0, i[1] ^ i[0]});
      end
    done("pin");
    for (int s = 0; s < 2; s++) begin
      cfg(8'h40 | 8'(s << 1));
      wr(OFF_CMPA_LO, 8'h00);
      wr(OFF_CMPA_HI, 8'h00);
      u_ptmr_pins.pulse(s == 0);
      rd(OFF_CMPA_LO, 32'h0);
      u_ptmr_pins.pulse(s == 1);
      apb(1'b0, OFF_CMPA_LO, 32'h0);
      chk({31'h0, r !== 32'h0}, 32'h1);
    end
    done("capture");
    tally_and_finish;
  end
endmodule // ptmr_top_tb
